// ### core/mfc_params.svh
// Constants for the modem flow-control block: offsets, fields, resets, timing
//
// Function
// - Auto terminal-ready: drive low at threshold, release below it.
// - Auto request-to-send: release at threshold, drive low below it.
// - Auto clear-to-send: finish character, idle until reasserted.
// - Flow-control characters ignore the clear-to-send input.
// - Auto data-set-ready: finish character, idle until reasserted.
// - Flow-control characters ignore the data-set-ready input.
// - Ch0 request-to-send strap high at start-up skips EEPROM preload.
// - Channel-0 terminal-ready pin read as debug strap, default low.
// - Ch1 request-to-send pin read as test-mode strap, default low.
// - Serial outputs idle high; serial inputs treat high as idle.
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MFC_CTRL_OFS     12'h000
`define MFC_MANUAL_OFS   12'h004
`define MFC_THRESH_OFS   12'h008
`define MFC_STATUS_OFS   12'h00c
`define MFC_PINS_OFS     12'h010

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define MFC_DTR_AUTO_LSB 0
`define MFC_RTS_AUTO_LSB 8
`define MFC_CTS_AUTO_LSB 16
`define MFC_DSR_AUTO_LSB 24
`define MFC_CTRL_RST     32'h0000_0000
`define MFC_MANUAL_RST   16'h0000
`define MFC_THRESH_RST   8'h10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MFC_CLK_PERIOD_PS 8000
`define MFC_STRAP_SETTLE_NS 100
`define MFC_STRAP_CYC \
    ((`MFC_STRAP_SETTLE_NS * 1000 + `MFC_CLK_PERIOD_PS - 1) / `MFC_CLK_PERIOD_PS)

`endif

// ### core/mfc_pkg.sv
// Types shared by the modem flow-control block
package mfc_pkg;
    typedef enum logic {
        ST_SETTLE,
        ST_RUN
    } mfc_state_type;
    typedef logic [7:0] mfc_chan_type;
endpackage

// ### core/mfc_flow_ctrl.sv
// Modem handshake, automatic flow control and start-up straps, eight channels
`timescale 1ns/100ps
`include "mfc_params.svh"

module mfc_flow_ctrl (
    input  wire logic             pclk,            // APB clock, 125 MHz
    input  wire logic             presetn,         // Async reset, active low
    input  wire logic             psel,            // APB select
    input  wire logic             penable,         // APB access phase
    input  wire logic             pwrite,          // APB write
    input  wire logic [11:0]      paddr,           // APB byte address
    input  wire logic [31:0]      pwdata,          // APB write data
    output logic      [31:0]      prdata,          // APB read data
    output logic                  pready,          // APB ready
    output logic                  pslverr,         // APB error, unmapped
    input  wire logic [63:0]      rx_level,        // Rx FIFO level, 8 bits/ch
    input  wire mfc_pkg::mfc_chan_type cts_n,      // Clear-to-send pins
    input  wire mfc_pkg::mfc_chan_type dsr_n,      // Data-set-ready pins
    input  wire mfc_pkg::mfc_chan_type sin,        // Serial data inputs
    input  wire mfc_pkg::mfc_chan_type tx_busy,    // Character in progress
    input  wire mfc_pkg::mfc_chan_type tx_serial,  // Framed serial from Tx
    input  wire logic             dtr0_strap_in,   // Ch0 terminal-ready pin in
    input  wire logic             rts0_strap_in,   // Ch0 request-to-send pin in
    input  wire logic             rts1_strap_in,   // Ch1 request-to-send pin in
    output mfc_pkg::mfc_chan_type dtr_n,           // Terminal-ready out
    output mfc_pkg::mfc_chan_type dtr_n_oe,        // Terminal-ready enable
    output mfc_pkg::mfc_chan_type rts_n,           // Request-to-send out
    output mfc_pkg::mfc_chan_type rts_n_oe,        // Request-to-send enable
    output mfc_pkg::mfc_chan_type sout,            // Serial data outputs
    output mfc_pkg::mfc_chan_type tx_data_ok,      // Data character may start
    output mfc_pkg::mfc_chan_type tx_fc_ok,        // Flow-control char may go
    output logic                  preload_bypass,  // EEPROM preload skipped
    output logic                  eeprom_load,     // EEPROM preload request
    output logic                  debug_strap_two, // Latched debug strap
    output logic                  test_mode        // Latched test-mode strap
);
    import mfc_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    mfc_state_type state_reg;
    logic [7:0]    settle_reg;
    logic [31:0]   ctrl_reg;
    logic [15:0]   manual_reg;
    logic [7:0]    thresh_reg;
    logic [7:0]    hold_reg;
    wire  [7:0]    hold_next;
    wire  [7:0]    dtr_next;
    wire  [7:0]    rts_next;
    logic [7:0]    sin_idle_reg;

    wire [7:0] dtr_auto = ctrl_reg[`MFC_DTR_AUTO_LSB +: 8];
    wire [7:0] rts_auto = ctrl_reg[`MFC_RTS_AUTO_LSB +: 8];
    wire [7:0] cts_auto = ctrl_reg[`MFC_CTS_AUTO_LSB +: 8];
    wire [7:0] dsr_auto = ctrl_reg[`MFC_DSR_AUTO_LSB +: 8];
    wire       run      = (state_reg == ST_RUN);

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire acc      = psel && penable && !pready;
    wire done     = psel && penable && pready;
    wire hit_ctrl = (paddr == `MFC_CTRL_OFS);
    wire hit_man  = (paddr == `MFC_MANUAL_OFS);
    wire hit_thr  = (paddr == `MFC_THRESH_OFS);
    wire hit_stat = (paddr == `MFC_STATUS_OFS);
    wire hit_pins = (paddr == `MFC_PINS_OFS);
    wire mapped   = hit_ctrl || hit_man || hit_thr || hit_stat || hit_pins;
    wire [31:0] status_word = {8'h00, sin_idle_reg, 4'h0, run, test_mode,
                               debug_strap_two, preload_bypass, hold_reg};
    wire [31:0] rd_word;
    assign rd_word = hit_ctrl ? ctrl_reg :
                     hit_man  ? {16'h0000, manual_reg} :
                     hit_thr  ? {24'h000000, thresh_reg} :
                     hit_stat ? status_word :
                     hit_pins ? {16'h0000, dsr_n, cts_n} : 32'h0000_0000;

    // One wait state: pready rises on the second access cycle, so prdata
    // and pslverr can be registered like every other output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            prdata  <= acc && !pwrite ? rd_word : 32'h0000_0000;
            pslverr <= acc && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `MFC_CTRL_RST;
            manual_reg <= `MFC_MANUAL_RST;
            thresh_reg <= `MFC_THRESH_RST;
        end else if (done && pwrite) begin
            if (hit_ctrl) begin
                ctrl_reg <= pwdata;
            end else if (hit_man) begin
                manual_reg <= pwdata[15:0];
            end else if (hit_thr) begin
                thresh_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Start-up strap sampling
    // ------------------------------------------------------------------------
    // Shared pins stay undriven while the straps settle; board pull-downs
    // give the default of zero when nothing is strapped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= ST_SETTLE;
            settle_reg      <= 8'((`MFC_STRAP_CYC) - 1);
            preload_bypass  <= 1'b0;
            eeprom_load     <= 1'b0;
            debug_strap_two <= 1'b0;
            test_mode       <= 1'b0;
        end else begin
            case (state_reg)
                ST_SETTLE: begin
                    if (settle_reg == 8'h00) begin
                        state_reg       <= ST_RUN;
                        preload_bypass  <= rts0_strap_in;
                        eeprom_load     <= !rts0_strap_in;
                        debug_strap_two <= dtr0_strap_in;
                        test_mode       <= rts1_strap_in;
                    end else begin
                        settle_reg <= settle_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Per-channel flow control
    // ------------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1) begin : g_ch
            wire [7:0] lvl   = rx_level[ch*8 +: 8];
            wire       full  = (lvl >= thresh_reg);
            wire       block = (cts_auto[ch] && cts_n[ch]) ||
                               (dsr_auto[ch] && dsr_n[ch]);
            // A character already on the wire is never cut short.
            assign hold_next[ch] = block && (hold_reg[ch] || !tx_busy[ch]);
            assign dtr_next[ch] = dtr_auto[ch] ? !full :
                                  !manual_reg[ch];
            assign rts_next[ch] = rts_auto[ch] ? full :
                                  !manual_reg[8 + ch];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg     <= 8'h00;
            dtr_n        <= 8'hff;
            rts_n        <= 8'hff;
            dtr_n_oe     <= 8'h00;
            rts_n_oe     <= 8'h00;
            sout         <= 8'hff;
            tx_data_ok   <= 8'h00;
            tx_fc_ok     <= 8'h00;
            sin_idle_reg <= 8'h00;
        end else begin
            hold_reg     <= hold_next;
            dtr_n        <= dtr_next;
            rts_n        <= rts_next;
            dtr_n_oe     <= {8{run}};
            rts_n_oe     <= {8{run}};
            sout         <= run ? tx_serial : 8'hff;
            sin_idle_reg <= sin;
            tx_data_ok   <= run ? ~hold_next : 8'h00;
            tx_fc_ok     <= {8{run}};
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_dtr_assert;
        @(posedge pclk) disable iff (!presetn)
        dtr_auto[0] && (rx_level[7:0] >= thresh_reg) |=> !dtr_n[0];
    endproperty
    a_dtr_assert: assert property (p_dtr_assert)
        else $error("terminal-ready not asserted at threshold");

    property p_dtr_release;
        @(posedge pclk) disable iff (!presetn)
        dtr_auto[3] && (rx_level[31:24] < thresh_reg) |=> dtr_n[3];
    endproperty
    a_dtr_release: assert property (p_dtr_release)
        else $error("terminal-ready not released below threshold");

    property p_rts_flow;
        @(posedge pclk) disable iff (!presetn)
        rts_auto[7] |=>
            rts_n[7] == ($past(rx_level[63:56]) >= $past(thresh_reg));
    endproperty
    a_rts_flow: assert property (p_rts_flow)
        else $error("request-to-send does not follow threshold");

    property p_cts_stop;
        @(posedge pclk) disable iff (!presetn)
        run && cts_auto[1] && cts_n[1] && !tx_busy[1] |=> !tx_data_ok[1];
    endproperty
    a_cts_stop: assert property (p_cts_stop)
        else $error("data allowed while clear-to-send deasserted");

    property p_dsr_stop;
        @(posedge pclk) disable iff (!presetn)
        run && dsr_auto[2] && dsr_n[2] && !tx_busy[2] |=> !tx_data_ok[2];
    endproperty
    a_dsr_stop: assert property (p_dsr_stop)
        else $error("data allowed while data-set-ready deasserted");

    property p_no_cut;
        @(posedge pclk) disable iff (!presetn)
        run && !hold_reg[1] && tx_busy[1] |=> !hold_reg[1];
    endproperty
    a_no_cut: assert property (p_no_cut)
        else $error("hold taken during a character");

    property p_fc_free;
        @(posedge pclk) disable iff (!presetn)
        run && (cts_n != 8'h00 || dsr_n != 8'h00) |=> tx_fc_ok == 8'hff;
    endproperty
    a_fc_free: assert property (p_fc_free)
        else $error("flow-control character blocked");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        !run && settle_reg == 8'h00 |=>
            preload_bypass == $past(rts0_strap_in) &&
            eeprom_load == !preload_bypass;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("preload bypass strap mislatched");

    property p_straps;
        @(posedge pclk) disable iff (!presetn)
        !run && settle_reg == 8'h00 |=>
            debug_strap_two == $past(dtr0_strap_in) &&
            test_mode == $past(rts1_strap_in);
    endproperty
    a_straps: assert property (p_straps)
        else $error("debug or test-mode strap mislatched");

    property p_pins_free;
        @(posedge pclk) disable iff (!presetn)
        !run |=> rts_n_oe[0] == 1'b0 || $past(settle_reg) == 8'h00;
    endproperty
    a_pins_free: assert property (p_pins_free)
        else $error("shared pin driven during strap sampling");

    c_run:     cover property (@(posedge pclk) disable iff (!presetn)
        $rose(run));
    c_cts:     cover property (@(posedge pclk) disable iff (!presetn)
        $rose(hold_reg[1]));
    c_dtr:     cover property (@(posedge pclk) disable iff (!presetn)
        $fell(dtr_n[0]));
    c_apb_err: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);
endmodule

// ### testbench/mfc_modem_model.sv
// Remote modem and board straps facing the flow-control block
`timescale 1ns/100ps
module mfc_modem_model (
    input  wire logic [7:0] hold_cts,     // Channels whose remote stops us
    input  wire logic [7:0] hold_dsr,     // Channels whose data set is down
    input  wire logic       bypass_strap, // Board fits the bypass strap
    input  wire logic [7:0] dtr_n,        // Terminal-ready from device
    input  wire logic [7:0] dtr_n_oe,     // Terminal-ready enable
    input  wire logic [7:0] rts_n,        // Request-to-send from device
    input  wire logic [7:0] rts_n_oe,     // Request-to-send enable
    output logic      [7:0] cts_n,        // Clear-to-send to device
    output logic      [7:0] dsr_n,        // Data-set-ready to device
    output logic      [7:0] sin,          // Serial line to device
    output logic            dtr0_pin,     // Resolved ch0 terminal-ready
    output logic            rts0_pin,     // Resolved ch0 request-to-send
    output logic            rts1_pin      // Resolved ch1 request-to-send
);
    // Deasserted handshake is the high level on these active-low lines
    assign cts_n = hold_cts;
    assign dsr_n = hold_dsr;
    // Nothing is sent towards the device, so the line rests at idle
    assign sin = 8'hff;
    // Weak pull-downs win when nobody drives; only ch0 RTS may be strapped
    assign dtr0_pin = dtr_n_oe[0] ? dtr_n[0] : 1'b0;
    assign rts1_pin = rts_n_oe[1] ? rts_n[1] : 1'b0;
    assign rts0_pin = rts_n_oe[0] ? rts_n[0] : bypass_strap;
endmodule

// ### testbench/mfc_flow_ctrl_test.sv
// Self-checking bench for the modem flow-control block
`timescale 1ns/100ps
`include "mfc_params.svh"
module mfc_flow_ctrl_test;
    import mfc_pkg::*;
    logic          pclk = 1'b0, presetn = 1'b0, bypass = 1'b0;
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0, prdata;
    logic          pready, pslverr, pre_byp, ee_load, dbg2, tmode;
    logic [63:0]   rx_level = 64'h0;
    mfc_chan_type  tx_busy = 8'h00, tx_serial = 8'hff;
    mfc_chan_type  hold_cts = 8'h00, hold_dsr = 8'h00, cts_n, dsr_n, sin;
    mfc_chan_type  dtr_n, dtr_n_oe, rts_n, rts_n_oe, sout, dok, fok;
    logic          dtr0_pin, rts0_pin, rts1_pin;
    int            failures = 0, samples_checked = 0;

    always #4 pclk = ~pclk;

    mfc_flow_ctrl mfc_flow_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_level(rx_level), .cts_n(cts_n),
        .dsr_n(dsr_n), .sin(sin), .tx_busy(tx_busy),
        .tx_serial(tx_serial), .dtr0_strap_in(dtr0_pin),
        .rts0_strap_in(rts0_pin), .rts1_strap_in(rts1_pin),
        .dtr_n(dtr_n), .dtr_n_oe(dtr_n_oe), .rts_n(rts_n),
        .rts_n_oe(rts_n_oe), .sout(sout), .tx_data_ok(dok),
        .tx_fc_ok(fok), .preload_bypass(pre_byp), .eeprom_load(ee_load),
        .debug_strap_two(dbg2), .test_mode(tmode));

    mfc_modem_model mfc_modem_model_inst (.hold_cts(hold_cts),
        .hold_dsr(hold_dsr), .bypass_strap(bypass), .dtr_n(dtr_n),
        .dtr_n_oe(dtr_n_oe), .rts_n(rts_n), .rts_n_oe(rts_n_oe),
        .cts_n(cts_n), .dsr_n(dsr_n), .sin(sin), .dtr0_pin(dtr0_pin),
        .rts0_pin(rts0_pin), .rts1_pin(rts1_pin));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic wrap_up;
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request is held until pready is seen high, then released at that edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Read right after the edge: these are the values the slave had
        // there, its own updates land later in the same time step
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            wrap_up;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk(e, 32'h0);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Hold one channel off by CTS or DSR; other held channel is not armed
    task automatic gate(input logic use_dsr);
        wr(`MFC_CTRL_OFS, use_dsr ? 32'h0200_0000 : 32'h0002_0000);
        @(posedge pclk);
        tx_busy <= 8'h02;
        if (use_dsr) hold_dsr <= 8'h0a;
        else hold_cts <= 8'h0a;
        step(3);
        chk(dok, 8'hff);
        rd(`MFC_PINS_OFS,
           use_dsr ? 32'h0000_0a00 : 32'h0000_000a);
        @(posedge pclk);
        tx_busy <= 8'h00;
        step(2);
        chk(dok, 8'hfd);
        chk(fok, 8'hff);
        @(posedge pclk);
        hold_cts <= 8'h00;
        hold_dsr <= 8'h00;
        step(2);
        chk(dok, 8'hff);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        wrap_up;
    end

    initial begin
        logic [31:0] q;
        logic        e;
        for (int b = 0; b < 2; b++) begin
            @(posedge pclk);
            presetn <= 1'b0;
            bypass <= b[0];
            step(16);
            chk(sout, 8'hff);
            @(posedge pclk);
            presetn <= 1'b1;
            step(16);
            chk(pre_byp, b);
            chk(ee_load, 1 - b);
            chk({dbg2, tmode}, 32'h0);
            chk({dtr_n_oe, rts_n_oe}, 32'hffff);
            chk(fok, 8'hff);
        end
        rd(`MFC_CTRL_OFS, 32'h0);
        rd(`MFC_THRESH_OFS, 32'h10);
        wr(`MFC_CTRL_OFS, 32'h0000_ffff);
        @(posedge pclk);
        rx_level <= {8{8'h0f}};
        step(3);
        chk(dtr_n, 8'hff);
        chk(rts_n, 8'h00);
        // Channel k holds level k, so a threshold of 4 splits the byte
        wr(`MFC_THRESH_OFS, 32'h4);
        @(posedge pclk);
        rx_level <= 64'h0706_0504_0302_0100;
        step(3);
        chk(dtr_n, 8'h0f);
        chk(rts_n, 8'hf0);
        gate(1'b0);
        gate(1'b1);
        @(posedge pclk);
        tx_serial <= 8'ha5;
        @(negedge pclk);
        chk(sout, 8'hff);
        step(1);
        chk(sout, 8'ha5);
        rd(`MFC_STATUS_OFS, 32'h00ff_0900);
        // Manual levels take over once automatic control is off
        wr(`MFC_CTRL_OFS, 32'h0);
        wr(`MFC_MANUAL_OFS, 32'h0000_0a05);
        step(2);
        chk(dtr_n, 8'hfa);
        chk(rts_n, 8'hf5);
        // Unmapped word answers with an error and zero data
        apb(1'b0, 12'h014, 32'h0, q, e);
        chk(e, 32'h1);
        chk(q, 32'h0);
        wrap_up;
    end
endmodule
